// *** rtl/ldpc_top.sv ***
// Overview of operation
// - group 10 write, upper six bits 001010: bit 1 sets address stepping direction
// - stepping bit 1, default: address counter increments after each data access
// - stepping bit 0: address counter decrements after each data access
// - group 10 write, upper five bits 01000: 3-bit polarity scheme from bits 2..0
// - scheme 000 frame inversion, default; 001..111 n-line inversion
// - n-line inversion flips drive polarity every n lines
// - frame inversion holds polarity a frame, flips on next frame
// - group 10 write, upper bits 100: 5-bit rate code for internal clock
// - rate code picks paired frame and clock frequency, 45 to 360 Hz
// - default rate code 00111: 80 Hz frame, 64000 Hz clock
// - internal clock high-low duty follows rate table, 50:50 to 5:95
// - group 10 write, upper bits 00100: bit 2 turns display on, default off
// - group 10 write, upper bits 000001: bit 1 mirrors segment order
// - group 11 write, upper bits 10000: bit 2 enables pump, default off
// - two-bit multiplier: 00 double, 01 triple, 10 quadruple, 11 direct
// - group 11 write, upper bits 101: data 4..0 into level code 8..4
// - group 11 write, upper bits 1001: data 3..0 into level code 3..0
// - reset restores all settings to defaults; memory is left alone
// - all settings readable through the status readout
`timescale 1ns/10ps
module ldpc_top
	import ldpc_pkg::*;
(
	// clock and reset
	input wire logic I_CLK,
	input wire logic I_RST,
	// command word from the bus framing
	input wire logic I_CMD_VALID,
	input wire logic I_CMD_READ,
	input wire logic [1:0] I_CMD_GROUP,
	input wire logic [7:0] I_CMD_DATA,
	input wire logic [2:0] I_STATUS_SEL,
	// memory access strobes
	input wire logic I_ADDR_LOAD,
	input wire logic [ldpc_pkg::ADDR_W-1:0] I_ADDR_VALUE,
	input wire logic I_DATA_ACCESS,
	// readout
	output logic [7:0] O_STATUS,
	output logic [ldpc_pkg::ADDR_W-1:0] O_ADDR,
	// applied settings
	output logic O_PANEL_ON,
	output logic O_SEGMENT_MIRROR,
	output logic O_PUMP_ON,
	output logic [1:0] O_PUMP_MULTIPLIER,
	output logic [8:0] O_DRIVE_LEVEL_CODE,
	output logic [2:0] O_POLARITY_SCHEME_CODE,
	output logic [4:0] O_RATE_CODE,
	// display timing
	output logic O_DISP_CLK,
	output logic O_POLARITY,
	output logic O_FRAME_START
);
	import ldpc_pkg::*;

	logic wr;
	logic step_reg;
	logic [2:0] scheme_pend_reg;
	logic [4:0] rate_pend_reg;
	logic [2:0] scheme_reg;
	logic [4:0] rate_reg;
	logic [CNT_W-1:0] tick_cnt_reg;
	logic [4:0] line_cnt_reg;
	logic [2:0] inv_cnt_reg;
	logic line_end;
	logic frame_end;
	ldpc_phase_e phase_reg;
	ldpc_settings_if rs();

	// ****************************************
	// command decode
	// ****************************************
	// only writes are decoded; reads of these groups are ignored
	assign wr = I_CMD_VALID && !I_CMD_READ;

	// stepping direction
	always_ff @(posedge I_CLK)
	begin
		if (I_RST)
			step_reg <= RST_STEP;
		else if (wr && I_CMD_GROUP == GRP_DISPLAY && I_CMD_DATA[7:2] == OP_STEP)
			step_reg <= I_CMD_DATA[STEP_BIT];
	end

	// panel and segment settings; low bits trusted to be zero by the host
	always_ff @(posedge I_CLK)
	begin
		if (I_RST)
		begin
			O_PANEL_ON <= RST_PANEL;
			O_SEGMENT_MIRROR <= RST_SEGMENT;
		end
		else if (wr && I_CMD_GROUP == GRP_DISPLAY)
		begin
			if (I_CMD_DATA[7:3] == OP_PANEL)
				O_PANEL_ON <= I_CMD_DATA[PANEL_BIT];
			if (I_CMD_DATA[7:2] == OP_SEGMENT)
				O_SEGMENT_MIRROR <= I_CMD_DATA[SEGMENT_BIT];
		end
	end

	// pending polarity scheme and rate, applied later at a frame edge
	always_ff @(posedge I_CLK)
	begin
		if (I_RST)
		begin
			scheme_pend_reg <= RST_POLARITY;
			rate_pend_reg <= RST_RATE;
		end
		else if (wr && I_CMD_GROUP == GRP_DISPLAY)
		begin
			if (I_CMD_DATA[7:3] == OP_POLARITY)
				scheme_pend_reg <= I_CMD_DATA[2:0];
			if (I_CMD_DATA[7:5] == OP_RATE)
				rate_pend_reg <= I_CMD_DATA[4:0];
		end
	end

	// pump and drive level; the two level halves load independently
	always_ff @(posedge I_CLK)
	begin
		if (I_RST)
		begin
			O_PUMP_ON <= RST_PUMP_ON;
			O_PUMP_MULTIPLIER <= RST_MULT;
			O_DRIVE_LEVEL_CODE <= RST_LEVEL;
		end
		else if (wr && I_CMD_GROUP == GRP_PUMP)
		begin
			if (I_CMD_DATA[7:3] == OP_PUMP)
			begin
				O_PUMP_ON <= I_CMD_DATA[PUMP_ON_BIT];
				O_PUMP_MULTIPLIER <= I_CMD_DATA[1:0];
			end
			if (I_CMD_DATA[7:5] == OP_LEVEL_HI)
				O_DRIVE_LEVEL_CODE[8:4] <= I_CMD_DATA[4:0];
			if (I_CMD_DATA[7:4] == OP_LEVEL_LO)
				O_DRIVE_LEVEL_CODE[3:0] <= I_CMD_DATA[3:0];
		end
	end

	// ****************************************
	// address counter
	// ****************************************
	// wraps at the counter width; memory contents live elsewhere and are untouched
	always_ff @(posedge I_CLK)
	begin
		if (I_RST)
			O_ADDR <= '0;
		else if (I_ADDR_LOAD)
			O_ADDR <= I_ADDR_VALUE;
		else if (I_DATA_ACCESS)
		begin
			if (step_reg)
				O_ADDR <= O_ADDR + 1'b1;
			else
				O_ADDR <= O_ADDR - 1'b1;
		end
	end

	// ****************************************
	// internal display clock
	// ****************************************
	assign rs.rate_code = rate_reg;
	ldpc_rate_table u_rate (
		.s(rs.table_side)
	);

	// high then low phase, period and duty from the rate table
	always_ff @(posedge I_CLK)
	begin
		if (I_RST)
		begin
			tick_cnt_reg <= '0;
			phase_reg <= LDPC_PHASE_HIGH;
			O_DISP_CLK <= 1'b0;
		end
		else if (tick_cnt_reg >= rs.half_period - 1'b1)
		begin
			tick_cnt_reg <= '0;
			phase_reg <= LDPC_PHASE_HIGH;
			O_DISP_CLK <= 1'b1;
		end
		else
		begin
			tick_cnt_reg <= tick_cnt_reg + 1'b1;
			case (phase_reg)
				LDPC_PHASE_HIGH:
					if (tick_cnt_reg >= rs.high_cycles - 1'b1)
					begin
						phase_reg <= LDPC_PHASE_LOW;
						O_DISP_CLK <= 1'b0;
					end
				default:
					O_DISP_CLK <= 1'b0;
			endcase
		end
	end

	// one line per display clock period, simplified timing model
	assign line_end = (tick_cnt_reg >= rs.half_period - 1'b1);
	assign frame_end = line_end && (line_cnt_reg == 5'(LINES_PER_FRAME - 1));

	// ****************************************
	// line, frame and polarity
	// ****************************************
	always_ff @(posedge I_CLK)
	begin
		if (I_RST)
		begin
			line_cnt_reg <= '0;
			O_FRAME_START <= 1'b0;
		end
		else
		begin
			O_FRAME_START <= frame_end;
			if (frame_end)
				line_cnt_reg <= '0;
			else if (line_end)
				line_cnt_reg <= line_cnt_reg + 1'b1;
		end
	end

	// settings switch only at frame edges so no frame mixes schemes
	always_ff @(posedge I_CLK)
	begin
		if (I_RST)
		begin
			scheme_reg <= RST_POLARITY;
			rate_reg <= RST_RATE;
		end
		else if (frame_end)
		begin
			scheme_reg <= scheme_pend_reg;
			rate_reg <= rate_pend_reg;
		end
	end

	// frame mode flips per frame; line mode flips every n lines
	always_ff @(posedge I_CLK)
	begin
		if (I_RST)
		begin
			O_POLARITY <= 1'b0;
			inv_cnt_reg <= '0;
		end
		else if (scheme_reg == 3'h0)
		begin
			inv_cnt_reg <= '0;
			if (frame_end)
				O_POLARITY <= ~O_POLARITY;
		end
		else if (line_end)
		begin
			if (inv_cnt_reg >= scheme_reg - 1'b1)
			begin
				inv_cnt_reg <= '0;
				O_POLARITY <= ~O_POLARITY;
			end
			else
				inv_cnt_reg <= inv_cnt_reg + 1'b1;
		end
	end

	// applied scheme and rate outputs
	always_ff @(posedge I_CLK)
	begin
		if (I_RST)
		begin
			O_POLARITY_SCHEME_CODE <= RST_POLARITY;
			O_RATE_CODE <= RST_RATE;
		end
		else
		begin
			O_POLARITY_SCHEME_CODE <= scheme_reg;
			O_RATE_CODE <= rate_reg;
		end
	end

	// ****************************************
	// status readout
	// ****************************************
	// reports written settings, so a readback right after a write sees it
	always_ff @(posedge I_CLK)
	begin
		if (I_RST)
			O_STATUS <= 8'h00;
		else
		begin
			case (I_STATUS_SEL)
				ST_SEL_1: O_STATUS <= {4'h0, step_reg, 3'h0};
				ST_SEL_2: O_STATUS <= {scheme_pend_reg, rate_pend_reg};
				ST_SEL_3: O_STATUS <= {O_PANEL_ON, 5'h00, O_SEGMENT_MIRROR, 1'b0};
				ST_SEL_4: O_STATUS <= {3'h0, O_PUMP_ON, 1'b0, O_PUMP_MULTIPLIER,
					O_DRIVE_LEVEL_CODE[8]};
				ST_SEL_5: O_STATUS <= O_DRIVE_LEVEL_CODE[7:0];
				default: O_STATUS <= 8'h00;
			endcase
		end
	end
endmodule

// *** rtl/ldpc_pkg.sv ***
package ldpc_pkg;
	// ****************************************
	// command groups and opcode patterns
	// ****************************************
	localparam logic [1:0] GRP_DISPLAY = 2'b10;
	localparam logic [1:0] GRP_PUMP = 2'b11;
	localparam logic [1:0] GRP_STATUS = 2'b00;
	localparam logic [5:0] OP_STEP = 6'b001010;
	localparam logic [4:0] OP_POLARITY = 5'b01000;
	localparam logic [2:0] OP_RATE = 3'b100;
	localparam logic [4:0] OP_PANEL = 5'b00100;
	localparam logic [5:0] OP_SEGMENT = 6'b000001;
	localparam logic [4:0] OP_PUMP = 5'b10000;
	localparam logic [2:0] OP_LEVEL_HI = 3'b101;
	localparam logic [3:0] OP_LEVEL_LO = 4'b1001;
	// ****************************************
	// field positions
	// ****************************************
	localparam int STEP_BIT = 1;
	localparam int PANEL_BIT = 2;
	localparam int SEGMENT_BIT = 1;
	localparam int PUMP_ON_BIT = 2;
	// ****************************************
	// reset values
	// ****************************************
	localparam logic RST_STEP = 1'b1;
	localparam logic [2:0] RST_POLARITY = 3'h0;
	localparam logic [4:0] RST_RATE = 5'h07;
	localparam logic RST_PANEL = 1'b0;
	localparam logic RST_SEGMENT = 1'b0;
	localparam logic RST_PUMP_ON = 1'b0;
	localparam logic [1:0] RST_MULT = 2'h0;
	localparam logic [8:0] RST_LEVEL = 9'h000;
	// ****************************************
	// status readout selectors
	// ****************************************
	localparam logic [2:0] ST_SEL_1 = 3'h1;
	localparam logic [2:0] ST_SEL_2 = 3'h2;
	localparam logic [2:0] ST_SEL_3 = 3'h3;
	localparam logic [2:0] ST_SEL_4 = 3'h4;
	localparam logic [2:0] ST_SEL_5 = 3'h5;
	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_HZ = 100000000;
	localparam int LINES_PER_FRAME = 18;
	localparam int ADDR_W = 7;
	localparam int CNT_W = 16;
	typedef enum logic [1:0] {LDPC_PHASE_HIGH, LDPC_PHASE_LOW} ldpc_phase_e;
endpackage

// *** rtl/ldpc_settings_if.sv ***
`timescale 1ns/10ps
interface ldpc_settings_if;
	logic [4:0] rate_code;
	logic [15:0] half_period;
	logic [15:0] high_cycles;
	modport owner (output rate_code, input half_period, input high_cycles);
	modport table_side (input rate_code, output half_period, output high_cycles);
endinterface

// *** rtl/ldpc_rate_table.sv ***
`timescale 1ns/10ps
module ldpc_rate_table
	import ldpc_pkg::*;
(
	ldpc_settings_if.table_side s
);
	// ****************************************
	// rate code to internal clock period and high time
	// ****************************************
	// each period is the system clock divided by the table clock frequency, rounded down
	function automatic logic [31:0] clk_hz_of(input logic [4:0] c);
		case (c)
			5'h00: clk_hz_of = 32'd36000;
			5'h01: clk_hz_of = 32'd39724;
			5'h02: clk_hz_of = 32'd44308;
			5'h03: clk_hz_of = 32'd48000;
			5'h04: clk_hz_of = 32'd52364;
			5'h05: clk_hz_of = 32'd54857;
			5'h06: clk_hz_of = 32'd60632;
			5'h07: clk_hz_of = 32'd64000;
			5'h08: clk_hz_of = 32'd67765;
			5'h09: clk_hz_of = 32'd72000;
			5'h0a: clk_hz_of = 32'd76800;
			5'h0b: clk_hz_of = 32'd82286;
			5'h0c: clk_hz_of = 32'd88615;
			5'h0d: clk_hz_of = 32'd96000;
			5'h0e: clk_hz_of = 32'd104727;
			5'h0f: clk_hz_of = 32'd115200;
			5'h10: clk_hz_of = 32'd128000;
			5'h11: clk_hz_of = 32'd144000;
			5'h12: clk_hz_of = 32'd164571;
			5'h13: clk_hz_of = 32'd192000;
			5'h14: clk_hz_of = 32'd230400;
			default: clk_hz_of = 32'd288000;
		endcase
	endfunction
	// high share of the period in percent
	function automatic logic [31:0] duty_of(input logic [4:0] c);
		case (c)
			5'h00, 5'h09: duty_of = 32'd50;
			5'h01: duty_of = 32'd44;
			5'h02, 5'h0c: duty_of = 32'd38;
			5'h03, 5'h0d, 5'h13: duty_of = 32'd33;
			5'h04, 5'h0e: duty_of = 32'd27;
			5'h05: duty_of = 32'd23;
			5'h06: duty_of = 32'd15;
			5'h07, 5'h10: duty_of = 32'd11;
			5'h08: duty_of = 32'd5;
			5'h0a: duty_of = 32'd46;
			5'h0b, 5'h12: duty_of = 32'd42;
			5'h0f, 5'h14: duty_of = 32'd20;
			default: duty_of = 32'd50;
		endcase
	endfunction
	logic [31:0] period;
	logic [31:0] high;
	// one divide per code; synthesis folds the constant cases
	always_comb
	begin
		period = 32'(CLK_HZ) / clk_hz_of(s.rate_code);
		high = (period * duty_of(s.rate_code)) / 32'd100;
		if (high == 32'd0)
		begin
			high = 32'd1;
		end
	end
	assign s.half_period = period[15:0];
	assign s.high_cycles = high[15:0];
endmodule

// *** bench/ldpc_top_asserts.sv ***
`timescale 1ns/10ps
module ldpc_top_asserts
	import ldpc_pkg::*;
(
	// clock and reset
	input wire logic I_CLK,
	input wire logic I_RST,
	// command side
	input wire logic I_CMD_VALID,
	input wire logic I_CMD_READ,
	input wire logic [1:0] I_CMD_GROUP,
	input wire logic [7:0] I_CMD_DATA,
	input wire logic I_ADDR_LOAD,
	input wire logic I_DATA_ACCESS,
	// watched outputs
	input wire logic [ldpc_pkg::ADDR_W-1:0] O_ADDR,
	input wire logic O_PANEL_ON,
	input wire logic O_SEGMENT_MIRROR,
	input wire logic O_PUMP_ON,
	input wire logic [1:0] O_PUMP_MULTIPLIER,
	input wire logic [8:0] O_DRIVE_LEVEL_CODE,
	input wire logic [2:0] O_POLARITY_SCHEME_CODE,
	input wire logic [4:0] O_RATE_CODE,
	input wire logic O_FRAME_START
);
	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (I_RST);
	logic d10;
	logic d11;
	logic step_reg;
	// qualified writes per group; reads never count
	assign d10 = I_CMD_VALID && !I_CMD_READ && I_CMD_GROUP == GRP_DISPLAY;
	assign d11 = I_CMD_VALID && !I_CMD_READ && I_CMD_GROUP == GRP_PUMP;
	// shadow stepping bit, needed to know which way the counter must move
	always_ff @(posedge I_CLK)
	begin
		if (I_RST)
			step_reg <= RST_STEP;
		else if (d10 && I_CMD_DATA[7:2] == OP_STEP)
			step_reg <= I_CMD_DATA[1];
	end
	property p_step;
		I_DATA_ACCESS && !I_ADDR_LOAD |=> O_ADDR == ($past(step_reg) ? $past(O_ADDR) + 1'b1
			: $past(O_ADDR) - 1'b1);
	endproperty
	a_step: assert property (p_step) else $error("address step wrong");
	property p_panel;
		d10 && I_CMD_DATA[7:3] == OP_PANEL |=> O_PANEL_ON == $past(I_CMD_DATA[2]);
	endproperty
	a_panel: assert property (p_panel) else $error("panel bit not taken");
	property p_mirror;
		d10 && I_CMD_DATA[7:2] == OP_SEGMENT |=> O_SEGMENT_MIRROR == $past(I_CMD_DATA[1]);
	endproperty
	a_mirror: assert property (p_mirror) else $error("mirror bit not taken");
	property p_pump;
		d11 && I_CMD_DATA[7:3] == OP_PUMP |=> {O_PUMP_ON, O_PUMP_MULTIPLIER} == $past(I_CMD_DATA[2:0]);
	endproperty
	a_pump: assert property (p_pump) else $error("pump fields not taken");
	property p_lvl_hi;
		d11 && I_CMD_DATA[7:5] == OP_LEVEL_HI |=> O_DRIVE_LEVEL_CODE[8:4] == $past(I_CMD_DATA[4:0])
			&& O_DRIVE_LEVEL_CODE[3:0] == $past(O_DRIVE_LEVEL_CODE[3:0]);
	endproperty
	a_lvl_hi: assert property (p_lvl_hi) else $error("level high part wrong");
	property p_lvl_lo;
		d11 && I_CMD_DATA[7:4] == OP_LEVEL_LO |=> O_DRIVE_LEVEL_CODE[3:0] == $past(I_CMD_DATA[3:0]);
	endproperty
	a_lvl_lo: assert property (p_lvl_lo) else $error("level low part wrong");
	property p_read;
		I_CMD_VALID && I_CMD_READ |=> $stable(O_PANEL_ON) && $stable(O_PUMP_ON)
			&& $stable(O_DRIVE_LEVEL_CODE);
	endproperty
	a_read: assert property (p_read) else $error("read changed a setting");
	// reset itself is the cause here, so the default disable is overridden
	property p_rst;
		disable iff (1'b0) I_RST |=> O_RATE_CODE == RST_RATE && O_POLARITY_SCHEME_CODE == RST_POLARITY
			&& O_PANEL_ON == RST_PANEL && O_DRIVE_LEVEL_CODE == RST_LEVEL && O_ADDR == '0;
	endproperty
	a_rst: assert property (p_rst) else $error("defaults not restored");
	property p_apply;
		$changed(O_RATE_CODE) || $changed(O_POLARITY_SCHEME_CODE) |-> O_FRAME_START
			|| $past(O_FRAME_START) || $past(O_FRAME_START, 2);
	endproperty
	a_apply: assert property (p_apply) else $error("scheme or rate changed mid frame");
endmodule
bind ldpc_top ldpc_top_asserts chk (.I_CLK(I_CLK), .I_RST(I_RST), .I_CMD_VALID(I_CMD_VALID),
	.I_CMD_READ(I_CMD_READ), .I_CMD_GROUP(I_CMD_GROUP), .I_CMD_DATA(I_CMD_DATA),
	.I_ADDR_LOAD(I_ADDR_LOAD), .I_DATA_ACCESS(I_DATA_ACCESS), .O_ADDR(O_ADDR),
	.O_PANEL_ON(O_PANEL_ON), .O_SEGMENT_MIRROR(O_SEGMENT_MIRROR), .O_PUMP_ON(O_PUMP_ON),
	.O_PUMP_MULTIPLIER(O_PUMP_MULTIPLIER), .O_DRIVE_LEVEL_CODE(O_DRIVE_LEVEL_CODE),
	.O_POLARITY_SCHEME_CODE(O_POLARITY_SCHEME_CODE), .O_RATE_CODE(O_RATE_CODE),
	.O_FRAME_START(O_FRAME_START));

// *** bench/ldpc_host_model.sv ***
`timescale 1ns/10ps
module ldpc_host_model
	import ldpc_pkg::*;
(
	// bus clock
	input wire logic i_clk,
	// command word towards the block
	output logic o_valid,
	output logic o_read,
	output logic [1:0] o_group,
	output logic [7:0] o_data
);
	// bus idle at start
	initial
	begin
		o_valid = 1'b0;
		o_read = 1'b0;
		o_group = 2'h0;
		o_data = 8'h00;
	end
	// one word per edge; valid stays up so words can follow back to back
	task automatic send(input logic [1:0] g, input logic [7:0] d, input logic rd);
		o_data = d;
		if (g == GRP_DISPLAY && (d[7:2] == OP_STEP || d[7:2] == OP_SEGMENT))
			o_data = d & 8'hfe;
		if (g == GRP_DISPLAY && d[7:3] == OP_PANEL)
			o_data = d & 8'hfc;
		o_valid = 1'b1;
		o_read = rd;
		o_group = g;
		@(posedge i_clk);
		#1;
	endtask
	// released bus shows a changed pattern, never the last word
	task automatic idle();
		o_valid = 1'b0;
		o_data = ~o_data;
	endtask
endmodule

// *** bench/tb.sv ***
`timescale 1ns/10ps
module tb;
	import ldpc_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [2:0] sel = 3'h0;
	logic ld = 1'b0;
	logic acc = 1'b0;
	logic probe = 1'b0;
	logic [6:0] aval = 7'h00;
	logic cv, cr;
	logic [1:0] cg, mul_o;
	logic [7:0] cd, st_o;
	logic [6:0] addr_o;
	logic pan_o, mir_o, pe_o, dclk, pol, fs;
	logic [8:0] lvl_o;
	logic [2:0] sch_o;
	logic [4:0] rate_o;
	logic m_step, m_pan, m_mir, m_pe;
	logic [2:0] m_sch;
	logic [4:0] m_rate;
	logic [1:0] m_mul;
	logic [8:0] m_lvl;
	logic [6:0] m_addr;
	logic [28:0] expq[$];
	logic [31:0] seed = 32'h00015017;
	logic [31:0] r;
	int n_errors = 0;
	int checked = 0;
	int n, k;
	always #5 clk = ~clk;
	ldpc_host_model host (.i_clk(clk), .o_valid(cv), .o_read(cr), .o_group(cg), .o_data(cd));
	ldpc_top uut (.I_CLK(clk), .I_RST(rst), .I_CMD_VALID(cv), .I_CMD_READ(cr), .I_CMD_GROUP(cg),
		.I_CMD_DATA(cd), .I_STATUS_SEL(sel), .I_ADDR_LOAD(ld), .I_ADDR_VALUE(aval),
		.I_DATA_ACCESS(acc), .O_STATUS(st_o), .O_ADDR(addr_o), .O_PANEL_ON(pan_o),
		.O_SEGMENT_MIRROR(mir_o), .O_PUMP_ON(pe_o), .O_PUMP_MULTIPLIER(mul_o),
		.O_DRIVE_LEVEL_CODE(lvl_o), .O_POLARITY_SCHEME_CODE(sch_o), .O_RATE_CODE(rate_o),
		.O_DISP_CLK(dclk), .O_POLARITY(pol), .O_FRAME_START(fs));
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic check(input logic [28:0] seen, input logic [28:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic tick();
		@(posedge clk);
		#1;
		if (++k > 40000)
		begin
			n_errors++;
			wrap_up();
		end
	endtask
	// status byte as the register layout defines it
	function automatic logic [7:0] st(input logic [2:0] s);
		case (s)
			ST_SEL_1: st = {4'h0, m_step, 3'h0};
			ST_SEL_2: st = {m_sch, m_rate};
			ST_SEL_3: st = {m_pan, 5'h00, m_mir, 1'b0};
			ST_SEL_4: st = {3'h0, m_pe, 1'b0, m_mul, m_lvl[8]};
			ST_SEL_5: st = m_lvl[7:0];
			default: st = 8'h00;
		endcase
	endfunction
	task automatic defaults();
		{m_step, m_sch, m_rate, m_pan} = {RST_STEP, RST_POLARITY, RST_RATE, RST_PANEL};
		{m_mir, m_pe, m_mul, m_lvl, m_addr} = {RST_SEGMENT, RST_PUMP_ON, RST_MULT, RST_LEVEL, 7'h00};
	endtask
	task automatic cmd(input logic [1:0] g, input logic [7:0] d, input logic rd);
		host.send(g, d, rd);
		if (!rd && g == GRP_DISPLAY)
		begin
			if (d[7:2] == OP_STEP) m_step = d[1];
			if (d[7:3] == OP_POLARITY) m_sch = d[2:0];
			if (d[7:5] == OP_RATE) m_rate = d[4:0];
			if (d[7:3] == OP_PANEL) m_pan = d[2];
			if (d[7:2] == OP_SEGMENT) m_mir = d[1];
		end
		if (!rd && g == GRP_PUMP)
		begin
			if (d[7:3] == OP_PUMP) {m_pe, m_mul} = d[2:0];
			if (d[7:5] == OP_LEVEL_HI) m_lvl[8:4] = d[4:0];
			if (d[7:4] == OP_LEVEL_LO) m_lvl[3:0] = d[3:0];
		end
	endtask
	// note the expectation; the monitor compares it mid-cycle after the status edge
	task automatic look(input logic [2:0] s);
		sel = s;
		expq.push_back({st(s), m_addr, m_pan, m_mir, m_pe, m_mul, m_lvl});
		@(posedge clk);
		#1;
		probe = 1'b1;
		@(posedge clk);
		#1;
		probe = 1'b0;
	endtask
	task automatic frame();
		k = 0;
		while (fs !== 1'b1)
			tick();
	endtask
	// monitor: oldest note against what the outputs show; falling edge so outputs have settled
	always @(negedge clk)
	begin
		if (probe && expq.size() > 0)
			check({st_o, addr_o, pan_o, mir_o, pe_o, mul_o, lvl_o}, expq.pop_front());
	end
	initial
	begin
		defaults();
		repeat (3) @(posedge clk);
		#1;
		rst = 1'b0;
		for (int s = 1; s <= 5; s++) look(s[2:0]);
		$display("test defaults done");
		for (int i = 0; i < 8; i++)
		begin
			r = xs();
			cmd(GRP_DISPLAY, {OP_STEP, i[0], 1'b1}, 1'b0);
			cmd(GRP_DISPLAY, {OP_POLARITY, i[2:0]}, 1'b0);
			cmd(GRP_DISPLAY, {OP_RATE, r[4:0]}, 1'b0);
			cmd(GRP_DISPLAY, {OP_PANEL, r[5], 2'b11}, 1'b0);
			cmd(GRP_DISPLAY, {OP_SEGMENT, r[6], 1'b1}, 1'b0);
			cmd(GRP_PUMP, {OP_PUMP, r[7], i[1:0]}, 1'b0);
			cmd(GRP_PUMP, {OP_LEVEL_HI, r[12:8]}, 1'b0);
			cmd(GRP_PUMP, {OP_LEVEL_LO, r[16:13]}, 1'b0);
			cmd(GRP_PUMP, {OP_PUMP, ~r[7], 2'b10}, 1'b1);
			cmd(GRP_STATUS, {OP_LEVEL_HI, ~r[12:8]}, 1'b0);
			host.idle();
			for (int s = 1; s <= 5; s++) look(s[2:0]);
			aval = r[23:17];
			ld = 1'b1;
			@(posedge clk);
			#1;
			ld = 1'b0;
			m_addr = aval;
			repeat (3)
			begin
				acc = 1'b1;
				@(posedge clk);
				#1;
				acc = 1'b0;
				m_addr = m_step ? m_addr + 7'h01 : m_addr - 7'h01;
			end
			look(3'h0);
		end
		$display("test commands done");
		rst = 1'b1;
		repeat (3) @(posedge clk);
		#1;
		rst = 1'b0;
		defaults();
		for (int s = 1; s <= 5; s++) look(s[2:0]);
		$display("test second reset done");
		cmd(GRP_DISPLAY, {OP_RATE, 5'h1f}, 1'b0);
		cmd(GRP_DISPLAY, {OP_POLARITY, 3'h3}, 1'b0);
		host.idle();
		check(29'(rate_o), 29'(RST_RATE));
		frame();
		repeat (3) @(posedge clk);
		#1;
		check(29'({sch_o, rate_o}), 29'h7f);
		frame();
		for (int m = 0; m < 2; m++)
		begin
			n = 0;
			r[0] = pol;
			do
			begin
				tick();
				n += (pol !== r[0]);
				r[0] = pol;
			end
			while (fs !== 1'b1);
			check(29'(n), m ? 29'd1 : 29'd6);
			if (m == 0)
			begin
				while (dclk !== 1'b0) tick();
				while (dclk !== 1'b1) tick();
				n = 0;
				while (dclk === 1'b1)
				begin
					tick();
					n++;
				end
				check(29'(n), 29'd173);
				cmd(GRP_DISPLAY, {OP_POLARITY, 3'h0}, 1'b0);
				host.idle();
				frame();
				tick();
				frame();
				tick();
				frame();
				check(29'(sch_o), 29'(RST_POLARITY));
			end
		end
		$display("test frames done");
		wrap_up();
	end
endmodule
